//--- rtl/rcmd_top.sv
`timescale 1ns/100ps
`include "rcmd_regs.svh"
module rcmd_top
  import rcmd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic hard_reset_in_ni,
  input wire logic power_on_reset_ni,
  input wire logic reset_config_strobe_ni,
  input wire logic [`RCMD_LOW_W-1:0] mode_clock_select_i,
  input wire logic [`RCMD_HIGH_W-1:0] mode_clock_high_field_i,
  input wire logic pci_clock_halve_i,
  input wire logic pci_host_mode_i,
  input wire logic [`RCMD_FREQ_W-1:0] in_clk_khz_i,
  output rcmd_samp_t active_o,
  output rcmd_cfg_t cfg_o,
  output logic [`RCMD_FREQ_W-1:0] core_khz_o,
  output logic [`RCMD_FREQ_W-1:0] cpm_khz_o,
  output logic [`RCMD_FREQ_W-1:0] pci_khz_o
);

  // Turn a strap set into multipliers and a PCI divider
  function automatic rcmd_cfg_t rcmd_decode(input rcmd_samp_t s);
    rcmd_cfg_t c;
    logic [`RCMD_MULT_W-1:0] low5;
    c = '0;
    low5 = {2'b00, s.low};
    case (s.high)
      `RCMD_GRP_BASIC:
      begin
        c.valid = 1'b1;
        // Upper code bit picks the fast input half of the table
        if (!s.low[2])
        begin
          c.cpm_x2 = s.low[1] ? 5'h08 : 5'h06;
          c.core_x2 = s.low[0] ? 5'h0A : 5'h08;
        end
        else
        begin
          c.cpm_x2 = s.low[1] ? 5'h05 : 5'h04;
          c.core_x2 = s.low[0] ? 5'h06 : 5'h05;
        end
      end
      `RCMD_GRP_EXT:
      begin
        if (s.low <= `RCMD_LOW_MAX)
        begin
          c.valid = 1'b1;
          c.cpm_x2 = 5'h04;
          c.core_x2 = 5'h08 + {low5[3:0], 1'b0};
        end
      end
      `RCMD_GRP_H35:
      begin
        if (s.host && s.low >= `RCMD_LOW_MIN_H35 && s.low <= `RCMD_LOW_MAX)
        begin
          c.valid = 1'b1;
          c.cpm_x2 = 5'h07;
          c.core_x2 = 5'h05 + low5;
          c.pci_div = `RCMD_DIV_4;
        end
      end
      `RCMD_GRP_H20:
      begin
        if (s.host && s.low <= `RCMD_LOW_MAX)
        begin
          c.valid = 1'b1;
          c.cpm_x2 = 5'h04;
          c.core_x2 = 5'h04 + low5;
          c.pci_div = `RCMD_DIV_3;
        end
      end
      `RCMD_GRP_H25:
      begin
        if (s.host && s.low <= `RCMD_LOW_MAX)
        begin
          c.valid = 1'b1;
          c.cpm_x2 = 5'h05;
          c.core_x2 = 5'h04 + low5;
          c.pci_div = `RCMD_DIV_4;
        end
      end
      // Agent-mode host codes and unlisted codes decode as invalid, all zero
      default:
      begin
        c = '0;
      end
    endcase
    // Halving only exists where a PCI divider does
    if (c.pci_div != 4'h0 && s.halve)
    begin
      c.pci_div = {c.pci_div[2:0], 1'b0};
    end
    return c;
  endfunction : rcmd_decode

  logic [`RCMD_PIN_W-1:0] pin_raw_w;
  logic [`RCMD_PIN_W-1:0] pin_s1_q;
  logic [`RCMD_PIN_W-1:0] pin_s2_q;
  logic hrst_act_w;
  logic por_act_w;
  logic strb_act_w;
  rcmd_samp_t samp_w;
  rcmd_samp_t pend_q;
  rcmd_samp_t pend_d;
  rcmd_samp_t act_q;
  rcmd_samp_t act_d;
  rcmd_cfg_t cfg_q;
  rcmd_cfg_t cfg_d;
  logic [24:0] core_prod_w;
  logic [24:0] cpm_prod_w;
  logic [`RCMD_FREQ_W-1:0] core_khz_q;
  logic [`RCMD_FREQ_W-1:0] cpm_khz_q;
  logic [`RCMD_FREQ_W-1:0] pci_khz_q;
  logic [`RCMD_FREQ_W-1:0] pci_khz_d;

  // All straps are asynchronous board levels, so bundle them for sync
  assign pin_raw_w = {hard_reset_in_ni, power_on_reset_ni,
    reset_config_strobe_ni, mode_clock_select_i,
    mode_clock_high_field_i, pci_clock_halve_i, pci_host_mode_i};

  // Two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_s1_q <= `RCMD_PIN_RST;
      pin_s2_q <= `RCMD_PIN_RST;
    end
    else
    begin
      pin_s1_q <= pin_raw_w;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Unpack the synchronised straps
  assign hrst_act_w = !pin_s2_q[11];
  assign por_act_w = !pin_s2_q[10];
  assign strb_act_w = !pin_s2_q[9];
  assign samp_w.low = pin_s2_q[8:6];
  // Without the strobe the high field is forced to the basic group
  assign samp_w.high = strb_act_w ? pin_s2_q[5:2] : `RCMD_GRP_BASIC;
  assign samp_w.halve = pin_s2_q[1];
  assign samp_w.host = pin_s2_q[0];

  // Pending set follows the straps only while hard reset is held
  assign pend_d = hrst_act_w ? samp_w : pend_q;
  // Active set is replaced only under power-on reset, never mid-run
  assign act_d = por_act_w ? pend_q : act_q;
  assign cfg_d = rcmd_decode(act_q);

  // Sampling and commit registers
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pend_q <= '0;
      act_q <= '0;
      cfg_q <= '0;
    end
    else
    begin
      pend_q <= pend_d;
      act_q <= act_d;
      cfg_q <= cfg_d;
    end
  end

  // Frequencies in kHz; half-step multipliers are halved by the slice
  assign core_prod_w = {5'h00, in_clk_khz_i} *
    {20'h0_0000, cfg_q.core_x2};
  assign cpm_prod_w = {5'h00, in_clk_khz_i} *
    {20'h0_0000, cfg_q.cpm_x2};
  // Divider is small and static, so a plain divide is cheap enough
  assign pci_khz_d = (cfg_q.pci_div == 4'h0) ? 20'h0_0000 :
    cpm_khz_q / {16'h0000, cfg_q.pci_div};

  // Frequency report registers
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      core_khz_q <= '0;
      cpm_khz_q <= '0;
      pci_khz_q <= '0;
    end
    else
    begin
      core_khz_q <= core_prod_w[20:1];
      cpm_khz_q <= cpm_prod_w[20:1];
      pci_khz_q <= pci_khz_d;
    end
  end

  // Outputs straight from flops
  assign active_o = act_q;
  assign cfg_o = cfg_q;
  assign core_khz_o = core_khz_q;
  assign cpm_khz_o = cpm_khz_q;
  assign pci_khz_o = pci_khz_q;

  // Checks run on the core clock and rest under reset
  default clocking rcmd_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_pend_sample;
    hrst_act_w |=> pend_q == $past(samp_w);
  endproperty
  a_pend_sample: assert property (p_pend_sample)
    else $error("pending set missed strap sample");

  property p_pend_hold;
    !hrst_act_w |=> $stable(pend_q);
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("pending set moved outside hard reset");

  property p_pin_path;
    hard_reset_in_ni == 1'b0 ##1 hard_reset_in_ni == 1'b0
      |=> hrst_act_w;
  endproperty
  a_pin_path: assert property (p_pin_path)
    else $error("hard reset not seen two cycles after pin");

  property p_basic_high;
    hrst_act_w && !strb_act_w |=> pend_q.high == `RCMD_GRP_BASIC;
  endproperty
  a_basic_high: assert property (p_basic_high)
    else $error("high field taken without strobe");

  property p_commit;
    por_act_w |=> act_q == $past(pend_q);
  endproperty
  a_commit: assert property (p_commit)
    else $error("active set not committed under power-on reset");

  property p_no_commit;
    !por_act_w |=> $stable(act_q);
  endproperty
  a_no_commit: assert property (p_no_commit)
    else $error("active set changed without power-on reset");

  property p_low_in;
    act_q.high == `RCMD_GRP_BASIC && !act_q.low[2] |=>
      cfg_q.cpm_x2 == ($past(act_q.low[1]) ? 5'h08 : 5'h06) &&
      cfg_q.core_x2 == ($past(act_q.low[0]) ? 5'h0A : 5'h08);
  endproperty
  a_low_in: assert property (p_low_in)
    else $error("slow basic mode decoded wrong");

  property p_high_in;
    act_q.high == `RCMD_GRP_BASIC && act_q.low[2] |=>
      cfg_q.cpm_x2 == ($past(act_q.low[1]) ? 5'h05 : 5'h04) &&
      cfg_q.core_x2 == ($past(act_q.low[0]) ? 5'h06 : 5'h05);
  endproperty
  a_high_in: assert property (p_high_in)
    else $error("fast basic mode decoded wrong");

  property p_ext;
    act_q.high == `RCMD_GRP_EXT && act_q.low == 3'h4 |=>
      cfg_q.valid && cfg_q.cpm_x2 == 5'h04 && cfg_q.core_x2 == 5'h10;
  endproperty
  a_ext: assert property (p_ext)
    else $error("extended mode top code decoded wrong");

  property p_h35;
    act_q.high == `RCMD_GRP_H35 && act_q.host && act_q.low == 3'h2
      && !act_q.halve |=> cfg_q.cpm_x2 == 5'h07 &&
      cfg_q.core_x2 == 5'h07 && cfg_q.pci_div == 4'h4;
  endproperty
  a_h35: assert property (p_h35)
    else $error("host 3.5 group decoded wrong");

  property p_h20;
    act_q.high == `RCMD_GRP_H20 && act_q.host && act_q.low == 3'h0
      |=> cfg_q.cpm_x2 == 5'h04 && cfg_q.core_x2 == 5'h04 &&
      cfg_q.pci_div == ($past(act_q.halve) ? 4'h6 : 4'h3);
  endproperty
  a_h20: assert property (p_h20)
    else $error("host 2 group decoded wrong");

  property p_h25;
    act_q.high == `RCMD_GRP_H25 && act_q.host && act_q.low == 3'h4
      |=> cfg_q.cpm_x2 == 5'h05 && cfg_q.core_x2 == 5'h08 &&
      cfg_q.pci_div == ($past(act_q.halve) ? 4'h8 : 4'h4);
  endproperty
  a_h25: assert property (p_h25)
    else $error("host 2.5 group decoded wrong");

  property p_no_host;
    !act_q.host |=> cfg_q.pci_div == 4'h0;
  endproperty
  a_no_host: assert property (p_no_host)
    else $error("PCI divider set outside host mode");

  // Product rebuilt from the inputs, bits 20..1 kept as the halving slice
  property p_core_f;
    1'b1 |=> {4'h0, core_khz_q, 1'b0} == ($past({5'h00, in_clk_khz_i} *
      {20'h0_0000, cfg_q.core_x2}) & 25'h01F_FFFE);
  endproperty
  a_core_f: assert property (p_core_f)
    else $error("core frequency wrong");

  property p_cpm_f;
    1'b1 |=> {4'h0, cpm_khz_q, 1'b0} == ($past({5'h00, in_clk_khz_i} *
      {20'h0_0000, cfg_q.cpm_x2}) & 25'h01F_FFFE);
  endproperty
  a_cpm_f: assert property (p_cpm_f)
    else $error("processor frequency wrong");

  // Divider must still be non-zero in the cycle the quotient is formed
  property p_pci_f;
    cfg_q.pci_div != 4'h0 ##1 $stable(cfg_q)
      |=> pci_khz_q == $past(cpm_khz_q) / {16'h0000, $past(cfg_q.pci_div)};
  endproperty
  a_pci_f: assert property (p_pci_f)
    else $error("PCI frequency wrong");

  c_ext: cover property (hrst_act_w && strb_act_w ##[1:8] por_act_w);
  c_host_half: cover property (cfg_q.pci_div == 4'h8);
  c_basic: cover property (cfg_q.valid && act_q.high == 4'h0);
  c_invalid: cover property (!cfg_q.valid && act_q.high == 4'hC);

endmodule : rcmd_top

//--- shared/rcmd_regs.svh
// What this block does
// - While hard reset is low, sample the three mode clock select pins.
// - With config strobe low, four data-bus bits extend the code above pins.
// - A newly sampled setup takes effect only once power-on reset asserts.
// - Codes 000/001: processor multiplier 3, core 4 or 5.
// - Codes 010/011: processor multiplier 4, core 4 or 5.
// - Codes 100/101: processor multiplier 2, core 2.5 or 3.
// - Codes 110/111: processor multiplier 2.5, core 2.5 or 3.
// - Codes 0001_000..100: processor multiplier 2, core 4 to 8.
// - Host codes 1001_010..100: processor 3.5, core 3.5-4.5, PCI divide 4/8.
// - Host codes 1010_000..100: processor 2, core 2-4, PCI divide 3/6.
// - Host codes 1011_000..100: processor 2.5, core 2-4, PCI divide 4/8.
// - PCI halve high in host mode doubles the PCI divider.
// - Core frequency is bus clock times core multiplier.
`ifndef RCMD_REGS_SVH
`define RCMD_REGS_SVH
`define RCMD_HIGH_W 4
`define RCMD_LOW_W 3
`define RCMD_MULT_W 5
`define RCMD_DIV_W 4
`define RCMD_FREQ_W 20
`define RCMD_PIN_W 12
`define RCMD_PIN_RST 12'h000
`define RCMD_GRP_BASIC 4'h0
`define RCMD_GRP_EXT 4'h1
`define RCMD_GRP_H35 4'h9
`define RCMD_GRP_H20 4'hA
`define RCMD_GRP_H25 4'hB
`define RCMD_LOW_MIN_H35 3'h2
`define RCMD_LOW_MAX 3'h4
`define RCMD_DIV_4 4'h4
`define RCMD_DIV_3 4'h3
`endif

//--- shared/rcmd_pkg.sv
`include "rcmd_regs.svh"
package rcmd_pkg;
  // Strap state caught during hard reset
  typedef struct packed {
    logic [`RCMD_HIGH_W-1:0] high;
    logic [`RCMD_LOW_W-1:0] low;
    logic halve;
    logic host;
  } rcmd_samp_t;

  // Decoded clock setup, multipliers held in half steps
  typedef struct packed {
    logic valid;
    logic [`RCMD_MULT_W-1:0] core_x2;
    logic [`RCMD_MULT_W-1:0] cpm_x2;
    logic [`RCMD_DIV_W-1:0] pci_div;
  } rcmd_cfg_t;
endpackage : rcmd_pkg

//--- tb/rcmd_board_model.sv
`timescale 1ns/100ps
// Board straps plus the hard reset config source facing the decoder
module rcmd_board_model (
  input wire logic core_clk_i,
  input wire logic [6:0] code_i,
  input wire logic ext_i,
  input wire logic host_i,
  input wire logic halve_i,
  output logic [2:0] mode_clock_select_o,
  output logic [3:0] data_bus_o,
  output logic reset_config_strobe_n_o,
  output logic pci_clock_halve_o,
  output logic pci_host_mode_o
);
  logic [3:0] spin_q = 4'h5;
  // Idle data bus keeps moving so a stale word never reads as config
  always @(posedge core_clk_i)
    spin_q <= ~spin_q + 4'h3;
  // Strap resistors are plain static levels
  assign mode_clock_select_o = code_i[2:0];
  // Config word bits appear only while the strobe is asserted
  assign reset_config_strobe_n_o = ~ext_i;
  assign data_bus_o = ext_i ? code_i[6:3] : spin_q;
  assign pci_clock_halve_o = halve_i;
  assign pci_host_mode_o = host_i;
endmodule : rcmd_board_model

//--- tb/rcmd_top_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module rcmd_top_tb_top;
  import rcmd_pkg::*;
  typedef struct packed {
    rcmd_samp_t s;
    rcmd_cfg_t c;
    logic [19:0] core, cpm, pci;
  } rcmd_exp_t;
  logic clk = 0, nrst_n = 0, hrst_n = 1, por_n = 1;
  logic ext = 0, host = 0, halve = 0;
  logic [6:0] code = 7'h00;
  logic [19:0] in_khz = 20'h0_8000;
  logic [2:0] sel;
  logic [3:0] hi;
  logic strb_n, hlv, hst;
  rcmd_samp_t active, pend_m = '0, act_m = '0;
  rcmd_cfg_t cfg;
  logic [19:0] core_khz, cpm_khz, pci_khz;
  rcmd_exp_t q[$], w;
  event chk_ev;
  int num_errors = 0, checked = 0;
  // 50 MHz core clock
  initial forever #10 clk = ~clk;
  rcmd_board_model u_rcmd_board_model (.core_clk_i(clk), .code_i(code),
    .ext_i(ext), .host_i(host), .halve_i(halve), .mode_clock_select_o(sel),
    .data_bus_o(hi), .reset_config_strobe_n_o(strb_n),
    .pci_clock_halve_o(hlv), .pci_host_mode_o(hst));
  rcmd_top u_rcmd_top (.core_clk_i(clk), .nrst_i(nrst_n),
    .hard_reset_in_ni(hrst_n), .power_on_reset_ni(por_n),
    .reset_config_strobe_ni(strb_n), .mode_clock_select_i(sel),
    .mode_clock_high_field_i(hi), .pci_clock_halve_i(hlv),
    .pci_host_mode_i(hst), .in_clk_khz_i(in_khz), .active_o(active),
    .cfg_o(cfg), .core_khz_o(core_khz), .cpm_khz_o(cpm_khz),
    .pci_khz_o(pci_khz));
  // Reference decode, multipliers kept in half steps
  function automatic rcmd_cfg_t exp_cfg(input rcmd_samp_t s);
    rcmd_cfg_t r;
    logic [2:0] l;
    r = '0;
    l = s.low;
    case (s.high)
      4'h0: r = '{1'b1, l[2] ? (l[0] ? 5'h06 : 5'h05) : (l[0] ? 5'h0a : 5'h08),
        l[2] ? (l[1] ? 5'h05 : 5'h04) : (l[1] ? 5'h08 : 5'h06), 4'h0};
      4'h1: if (l <= 3'h4) r = '{1'b1, 5'(8 + 2 * l), 5'h04, 4'h0};
      4'h9: if (s.host && l >= 3'h2 && l <= 3'h4)
        r = '{1'b1, 5'(5 + l), 5'h07, s.halve ? 4'h8 : 4'h4};
      4'ha: if (s.host && l <= 3'h4)
        r = '{1'b1, 5'(4 + l), 5'h04, s.halve ? 4'h6 : 4'h3};
      4'hb: if (s.host && l <= 3'h4)
        r = '{1'b1, 5'(4 + l), 5'h05, s.halve ? 4'h8 : 4'h4};
      default: r = '0;
    endcase
    return r;
  endfunction : exp_cfg
  // One reset sequence; the expected result is queued for the watcher
  task automatic apply(input logic [6:0] c, input logic x, h, v, hr, pr);
    rcmd_exp_t e;
    @(posedge clk);
    #1;
    code = c;
    ext = x;
    host = h;
    halve = v;
    in_khz = 20'(2 * ($urandom % 50000) + 1000);
    hrst_n = ~hr;
    por_n = ~pr;
    repeat (6) @(posedge clk);
    #1;
    hrst_n = 1;
    por_n = 1;
    if (hr) pend_m = '{x ? c[6:3] : 4'h0, c[2:0], v, h};
    if (pr) act_m = pend_m;
    repeat (8) @(posedge clk);
    #1;
    e.s = act_m;
    e.c = exp_cfg(act_m);
    e.core = 20'((32'(in_khz) * e.c.core_x2) / 2); // reference
    e.cpm = 20'((32'(in_khz) * e.c.cpm_x2) / 2);
    e.pci = (e.c.pci_div == 4'h0) ? 20'h0 : 20'(e.cpm / e.c.pci_div);
    q.push_back(e);
    ->chk_ev;
  endtask : apply
  // Watcher takes the oldest note whenever a result is due
  initial forever
  begin
    @(chk_ev);
    w = q.pop_front();
    `CHK(active, w.s)
    `CHK(cfg, w.c)
    `CHK(cfg.pci_div, w.c.pci_div)
    `CHK(core_khz, w.core)
    `CHK(cpm_khz, w.cpm)
    `CHK(pci_khz, w.pci)
  end
  task automatic results();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  // Hang guard, well past the full sequence length
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
  // Main sequence
  initial
  begin
    void'($urandom(83501));
    repeat (10) @(posedge clk);
    #1 nrst_n = 1;
    // Basic codes with junk on the data bus and the strobe idle
    for (int i = 0; i < 8; i++)
      apply({4'($urandom), 3'(i)}, 0, 1'($urandom), 1'($urandom), 1, 1);
    // Every extended code, agent and host strap, random halve
    for (int p = 0; p < 2; p++)
      for (int h = 0; h < 16; h++)
        for (int l = 0; l < 8; l++)
          apply({4'(h), 3'(l)}, 1, p[0], 1'($urandom), 1, 1);
    // Hard reset alone must not commit; POR alone then commits old pend
    apply({4'ha, 3'h2}, 1, 1, 0, 1, 0);
    apply({4'h1, 3'h0}, 1, 0, 1, 0, 1);
    apply({4'h0, 3'h5}, 0, 0, 0, 1, 0);
    apply({4'h9, 3'h4}, 1, 1, 1, 0, 1);
    results();
  end
endmodule : rcmd_top_tb_top
